// file: bgm_pkg.sv
// package for the battery gauge mode controller: register map, fields, timing
// assumes a single 250 MHz hclk domain and an AHB-Lite register bus
package bgm_pkg;

    // --------
    // register byte offsets
    // --------
    localparam logic [7:0] BGM_OFS_CMD    = 8'h00; // subcommand strobe (write)
    localparam logic [7:0] BGM_OFS_CFG    = 8'h04; // operation config word
    localparam logic [7:0] BGM_OFS_THR    = 8'h08; // charge thresholds
    localparam logic [7:0] BGM_OFS_SOC    = 8'h0C; // state of charge input
    localparam logic [7:0] BGM_OFS_TEMP   = 8'h10; // temperature in use / host write
    localparam logic [7:0] BGM_OFS_STATUS = 8'h14; // flags and mode (read)
    localparam logic [7:0] BGM_OFS_EVT    = 8'h18; // platform events (write)

    // --------
    // subcommand codes
    // --------
    localparam logic [15:0] BGM_CMD_ENTER_CFG  = 16'h0013;
    localparam logic [15:0] BGM_CMD_POWER_ARM  = 16'h001B;
    localparam logic [15:0] BGM_CMD_POWER_OFF  = 16'h001C;
    localparam logic [15:0] BGM_CMD_HIBERNATE  = 16'h0011;
    localparam logic [15:0] BGM_CMD_RESET      = 16'h0041;
    localparam logic [15:0] BGM_CMD_SOFT_RESET = 16'h0042;
    localparam logic [15:0] BGM_CMD_LEAVE_CFG  = 16'h0043;
    localparam logic [15:0] BGM_CMD_LEAVE_RESIM= 16'h0044;

    // --------
    // field positions
    // --------
    localparam int BGM_CFG_EXTERNAL_TEMP_SELECT_BIT = 0;   // external_temp_select
    localparam int BGM_CFG_SLEEP_BIT = 1;   // sleep enable
    localparam int BGM_EVT_BAT_BIT   = 0;   // battery present level
    localparam int BGM_EVT_IDLE_BIT  = 1;   // light load, may sleep
    localparam int BGM_EVT_OCV_BIT   = 2;   // ocv measurement done pulse
    localparam int BGM_EVT_WAKE_BIT  = 3;   // host traffic addressed to gauge

    localparam logic [31:0] BGM_CFG_RESET = 32'h0000_0002;
    localparam logic [31:0] BGM_THR_RESET = 32'h0005_0A0F; // set1 15, fset 10, fclr 5
    localparam logic [7:0]  BGM_THR_OFF   = 8'hFF;         // -1: final flag inoperative

    // --------
    // timing
    // --------
    localparam longint BGM_CLK_HZ       = 250_000_000;
    localparam longint BGM_WAKE_MIN_US  = 200;
    localparam longint BGM_CFG_TMO_S    = 240;
    localparam longint BGM_WAKE_CYC     = (BGM_WAKE_MIN_US * BGM_CLK_HZ + 999_999) / 1_000_000;
    localparam longint BGM_CFG_TMO_CYC  = BGM_CFG_TMO_S * BGM_CLK_HZ;
    localparam longint BGM_SLEEP_TICK   = 64'd5_000_000_000; // 20 s wake interval

    // --------
    // types
    // --------
    typedef enum logic [6:0] {
        BGM_ST_POR      = 7'h01,
        BGM_ST_INIT     = 7'h02,
        BGM_ST_NORMAL   = 7'h04,
        BGM_ST_CFGUP    = 7'h08,
        BGM_ST_SLEEP    = 7'h10,
        BGM_ST_HIBER    = 7'h20,
        BGM_ST_SHUTDOWN = 7'h40
    } bgm_state_type;

    typedef struct packed {
        logic [7:0] final_clear;
        logic [7:0] final_set;
        logic [7:0] low_set;
    } bgm_thr_type;

    typedef struct packed {
        logic low_charge_warning_flag;
        logic final_discharge_flag;
        logic defaults_restored_flag;
        logic config_update_active_flag;
        logic init_complete_bit;
        logic capacity_learned_bit;
        logic impedance_learned_bit;
        logic power_off_armed;
    } bgm_flags_type;

endpackage

// file: bgm_mode_ctrl.sv
// mode and status-flag controller of a single-cell battery gauge
// assumes one hclk domain, AHB-Lite slave with hready from hreadyout, pins synchronous
//
// Functional notes
// - low charge flag sets below first threshold, clears above it
// - final discharge flag sets below its own set threshold
// - final set threshold of minus one never sets final discharge flag
// - final discharge flag clears only above separate clear threshold
// - external select clear feeds internal sensor reading to gauging
// - external select set: host-written temperature is used for gauging
// - temperature read returns whichever value gauging currently uses
// - power-up from off or shutdown performs reset then initialization
// - normal mode is fully powered and runs every task
// - sleep gates the fast clock but wakes periodically to measure
// - hibernate stays low power until host communication arrives
// - shutdown disables regulator output, losing volatile data
// - power-off takes effect only right after the arm subcommand
// - shutdown exit needs general output pin high at least 200 us
// - power-on reset copies rom defaults to ram before initialization
// - no battery detected keeps initialization with processor halted
// - power-on reset or reset subcommand sets defaults restored flag
// - battery insertion starts ocv measurement, clears learned bits
// - initialization complete bit sets when initialization finishes
// - enter update subcommand in normal mode sets update flag and suspends gauging
// - any exit subcommand resumes gauging, clears restored and update flags
// - update mode leaves by itself after about 240 seconds
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

module bgm_mode_ctrl
    import bgm_pkg::*;
#(
    parameter longint CFG_TMO_CYC = bgm_pkg::BGM_CFG_TMO_CYC, // update timeout cycles
    parameter longint WAKE_CYC    = bgm_pkg::BGM_WAKE_CYC,    // shutdown wake qualify
    parameter longint SLEEP_TICK  = bgm_pkg::BGM_SLEEP_TICK   // sleep measure interval
) (
    input  wire logic                  hclk,            // bus clock
    input  wire logic                  hresetn,         // async reset, low
    input  wire logic                  hsel,            // slave select
    input  wire logic [31:0]           haddr,           // byte address
    input  wire logic [1:0]            htrans,          // transfer type
    input  wire logic                  hwrite,          // write not read
    input  wire logic [2:0]            hsize,           // transfer size
    input  wire logic                  hready,          // bus ready in
    input  wire logic [31:0]           hwdata,          // write data
    output logic [31:0]                hrdata,          // read data
    output logic                       hreadyout,       // slave ready
    output logic                       hresp,           // always okay

    input  wire logic [15:0]           internal_temp,   // on-chip sensor reading
    input  wire logic                  general_output_pin_in,        // general_output_pin level in
    output logic                       general_output_pin_out,       // general_output_pin drive
    output logic                       general_output_pin_oe,        // general_output_pin enable

    output logic [15:0]                gauge_temp,      // temperature used by gauging
    output logic                       gauging_run,     // gauging active
    output logic                       cpu_halt,        // processor halted
    output logic                       hf_clk_en,       // fast oscillator gate
    output logic                       ldo_en,          // regulator output enable
    output logic                       measure_pulse,   // measurement request
    output logic                       rom_copy,        // copy defaults to ram
    output logic                       ocv_start,       // begin ocv measurement
    output bgm_pkg::bgm_state_type     mode             // current mode
);
    import bgm_pkg::*;

    // --------
    // bus address phase capture
    // --------

    logic        ap_wr_q, ap_rd_q;
    logic [7:0]  ap_ofs_q;
    wire  logic  ap_valid = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q  <= 1'b0;
            ap_rd_q  <= 1'b0;
            ap_ofs_q <= 8'h00;
        end else begin
            ap_wr_q  <= ap_valid && hwrite;
            ap_rd_q  <= ap_valid && !hwrite;
            ap_ofs_q <= ap_valid ? haddr[7:0] : ap_ofs_q;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire logic wr_cmd  = ap_wr_q && (ap_ofs_q == BGM_OFS_CMD);
    wire logic wr_cfg  = ap_wr_q && (ap_ofs_q == BGM_OFS_CFG);
    wire logic wr_thr  = ap_wr_q && (ap_ofs_q == BGM_OFS_THR);
    wire logic wr_soc  = ap_wr_q && (ap_ofs_q == BGM_OFS_SOC);
    wire logic wr_temp = ap_wr_q && (ap_ofs_q == BGM_OFS_TEMP);
    wire logic wr_evt  = ap_wr_q && (ap_ofs_q == BGM_OFS_EVT);
    wire logic [15:0] cmd = hwdata[15:0];

    // --------
    // software registers
    // --------

    logic [31:0]    cfg_q;
    bgm_thr_type    thr_q;
    logic [7:0]     soc_q;
    logic [15:0]    host_temp_q;
    logic           bat_q, idle_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q       <= BGM_CFG_RESET;
            thr_q       <= bgm_thr_type'(BGM_THR_RESET[23:0]);
            soc_q       <= 8'h64;
            host_temp_q <= 16'h0000;
            bat_q       <= 1'b0;
            idle_q      <= 1'b0;
        end else begin
            if (wr_cfg)
                cfg_q <= hwdata;

            if (wr_thr)
                thr_q <= bgm_thr_type'(hwdata[23:0]);

            if (wr_soc)
                soc_q <= hwdata[7:0];

            if (wr_temp)
                host_temp_q <= hwdata[15:0];

            if (wr_evt) begin
                bat_q  <= hwdata[BGM_EVT_BAT_BIT];
                idle_q <= hwdata[BGM_EVT_IDLE_BIT];
            end
        end
    end

    // kept combinational so a read shows the live source
    wire logic ext_sel = cfg_q[BGM_CFG_EXTERNAL_TEMP_SELECT_BIT];
    assign gauge_temp = ext_sel ? host_temp_q : internal_temp;

    wire logic ocv_done = wr_evt && hwdata[BGM_EVT_OCV_BIT];
    wire logic host_hit = wr_evt && hwdata[BGM_EVT_WAKE_BIT];

    // --------
    // subcommand decode
    // --------

    // unknown codes decode to nothing, but still wake from hibernate and clear the power-off arm
    wire logic c_enter  = wr_cmd && (cmd == BGM_CMD_ENTER_CFG);
    wire logic c_arm    = wr_cmd && (cmd == BGM_CMD_POWER_ARM);
    wire logic c_off    = wr_cmd && (cmd == BGM_CMD_POWER_OFF);
    wire logic c_hiber  = wr_cmd && (cmd == BGM_CMD_HIBERNATE);
    wire logic c_reset  = wr_cmd && (cmd == BGM_CMD_RESET);
    wire logic c_leave  = wr_cmd && ((cmd == BGM_CMD_SOFT_RESET) ||
                                     (cmd == BGM_CMD_LEAVE_CFG) ||
                                     (cmd == BGM_CMD_LEAVE_RESIM));

    // --------
    // counters: update timeout, shutdown wake, sleep tick
    // --------

    // every counter saturates or clears, none can wrap
    bgm_state_type state_q, state_d;
    logic [39:0]   tmo_q;
    logic [39:0]   wake_q;
    logic [39:0]   tick_q;
    wire  logic    in_cfg   = (state_q == BGM_ST_CFGUP);
    wire  logic    tmo_hit  = in_cfg && (tmo_q >= 40'(CFG_TMO_CYC - 1));
    wire  logic    wake_ok  = (wake_q >= 40'(WAKE_CYC));
    wire  logic    tick_hit = (tick_q >= 40'(SLEEP_TICK - 1));
    logic          gp_prev_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmo_q     <= 40'h00_0000_0000;
            wake_q    <= 40'h00_0000_0000;
            tick_q    <= 40'h00_0000_0000;
            gp_prev_q <= 1'b1;
        end else begin
            // restart at entry, hold at zero outside the mode
            tmo_q <= (in_cfg && state_d == BGM_ST_CFGUP) ? tmo_q + 40'h1 : 40'h0;

            gp_prev_q <= general_output_pin_in;
            // a low level arms the rising edge; the high time is counted afterwards
            if (state_q != BGM_ST_SHUTDOWN || !general_output_pin_in)
                wake_q <= 40'h0;
            else if (gp_prev_q || wake_q != 40'h0)
                wake_q <= wake_ok ? wake_q : wake_q + 40'h1;

            // tick runs only while asleep
            tick_q <= (state_q != BGM_ST_SLEEP || tick_hit) ? 40'h0 : tick_q + 40'h1;
        end
    end

    // a high already present when shutdown starts is no qualified rise
    logic gp_armed_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            gp_armed_q <= 1'b0;
        else if (state_q != BGM_ST_SHUTDOWN)
            gp_armed_q <= 1'b0;
        else if (!general_output_pin_in)
            gp_armed_q <= 1'b1;
    end

    // --------
    // mode machine
    // --------

    logic por_done_q;
    // flags feed the machine, so declared ahead of it
    bgm_flags_type flags_q, flags_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            BGM_ST_POR:
                state_d = BGM_ST_INIT;

            BGM_ST_INIT:
                if (bat_q && ocv_done)
                    state_d = BGM_ST_NORMAL;

            BGM_ST_NORMAL: begin
                if (c_enter)
                    state_d = BGM_ST_CFGUP;
                else if (c_hiber)
                    state_d = BGM_ST_HIBER;
                else if (idle_q && cfg_q[BGM_CFG_SLEEP_BIT])
                    state_d = BGM_ST_SLEEP;
            end

            BGM_ST_CFGUP:
                if (c_leave || tmo_hit)
                    state_d = BGM_ST_NORMAL;

            BGM_ST_SLEEP:
                if (!idle_q || c_enter || c_hiber)
                    state_d = BGM_ST_NORMAL;

            BGM_ST_HIBER:
                if (host_hit || wr_cmd)
                    state_d = BGM_ST_NORMAL;

            BGM_ST_SHUTDOWN:
                if (gp_armed_q && wake_ok)
                    state_d = BGM_ST_POR;

            default:
                state_d = BGM_ST_POR;
        endcase

        // later overrides win: battery loss beats all but shutdown and power-on reset
        if (c_reset && state_q != BGM_ST_SHUTDOWN)
            state_d = BGM_ST_POR;
        if (flags_q.power_off_armed && c_off && state_q != BGM_ST_SHUTDOWN)
            state_d = BGM_ST_SHUTDOWN;
        if (!bat_q && state_q != BGM_ST_SHUTDOWN && state_q != BGM_ST_POR)
            state_d = BGM_ST_INIT;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q    <= BGM_ST_POR;
            por_done_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            por_done_q <= (state_q == BGM_ST_POR);
        end
    end

    // --------
    // status flags
    // --------

    wire logic in_por   = (state_q == BGM_ST_POR);
    wire logic bat_rise = wr_evt && hwdata[BGM_EVT_BAT_BIT] && !bat_q;

    always_comb begin
        flags_d = flags_q;
        // low charge follows one threshold both ways
        if (soc_q < thr_q.low_set)
            flags_d.low_charge_warning_flag = 1'b1;
        else if (soc_q > thr_q.low_set)
            flags_d.low_charge_warning_flag = 1'b0;

        if (flags_q.final_discharge_flag && soc_q > thr_q.final_clear)
            flags_d.final_discharge_flag = 1'b0;
        else if (thr_q.final_set != BGM_THR_OFF && soc_q < thr_q.final_set)
            flags_d.final_discharge_flag = 1'b1;

        if (c_leave && in_cfg) begin
            flags_d.defaults_restored_flag    = 1'b0;
            flags_d.config_update_active_flag = 1'b0;
        end

        if (tmo_hit)
            flags_d.config_update_active_flag = 1'b0;
        if (c_enter && (state_q == BGM_ST_NORMAL || state_q == BGM_ST_SLEEP))
            flags_d.config_update_active_flag = 1'b1;

        if (state_q == BGM_ST_INIT && state_d == BGM_ST_NORMAL)
            flags_d.init_complete_bit = 1'b1;

        if (bat_rise) begin
            flags_d.capacity_learned_bit  = 1'b0;
            flags_d.impedance_learned_bit = 1'b0;
        end

        // arm is consumed by the very next subcommand
        if (wr_cmd)
            flags_d.power_off_armed = c_arm;

        // reset wins over every other update
        if (in_por || c_reset) begin
            flags_d.defaults_restored_flag    = 1'b1;
            flags_d.config_update_active_flag = 1'b0;
            flags_d.init_complete_bit         = 1'b0;
            flags_d.power_off_armed           = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

    // --------
    // outputs to the rest of the gauge
    // --------

    // levels follow the next mode so they switch with it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gauging_run   <= 1'b0;
            cpu_halt      <= 1'b1;
            hf_clk_en     <= 1'b1;
            ldo_en        <= 1'b1;
            measure_pulse <= 1'b0;
            rom_copy      <= 1'b0;
            ocv_start     <= 1'b0;
        end else begin
            gauging_run   <= (state_d == BGM_ST_NORMAL) || (state_d == BGM_ST_SLEEP);
            cpu_halt      <= (state_d == BGM_ST_INIT) && !bat_q;
            hf_clk_en     <= (state_d != BGM_ST_SLEEP) && (state_d != BGM_ST_HIBER) &&
                             (state_d != BGM_ST_SHUTDOWN);
            ldo_en        <= (state_d != BGM_ST_SHUTDOWN);

            measure_pulse <= (state_q == BGM_ST_SLEEP) && tick_hit;
            rom_copy      <= in_por;
            ocv_start     <= bat_rise || (por_done_q && bat_q);
        end
    end

    assign general_output_pin_out = 1'b0;
    assign general_output_pin_oe  = 1'b0;
    assign mode      = state_q;

    // --------
    // read mux
    // --------

    wire logic [31:0] rd_status = {17'h0_0000, state_q, flags_q};
    logic [31:0]      rdata_d;

    always_comb begin
        unique case (ap_ofs_q)
            BGM_OFS_CFG:    rdata_d = cfg_q;
            BGM_OFS_THR:    rdata_d = {8'h00, thr_q};
            BGM_OFS_SOC:    rdata_d = {24'h00_0000, soc_q};
            BGM_OFS_TEMP:   rdata_d = {16'h0000, gauge_temp};
            BGM_OFS_STATUS: rdata_d = rd_status;
            default:        rdata_d = 32'h0000_0000;
        endcase
    end

    assign hrdata = ap_rd_q ? rdata_d : 32'h0000_0000;

endmodule

`default_nettype wire

// file: bgm_host_model.sv
// host side model: on-chip sensor level and the wake drive of the pin
// assumes hclk from the bench; the host holds the pin low when idle
`timescale 1ns/10ps
`default_nettype none
module bgm_host_model (
    input  wire logic        hclk,      // clock
    output logic [15:0]      sens_temp, // sensor level
    output logic             pin_drv    // wake drive
);
    initial begin
        sens_temp = 16'h0123;
        pin_drv   = 1'b0;
    end
    // raise the pin for n cycles, then back low
    task automatic wake(input int n);
        @(posedge hclk);
        pin_drv <= 1'b1;
        repeat (n) @(posedge hclk);
        pin_drv <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: bgm_mode_ctrl_properties.sv
// port checker of the mode controller
// assumes one hclk domain; bound to every instance below
`timescale 1ns/10ps
`default_nettype none
module bgm_mode_ctrl_properties
    import bgm_pkg::*;
#(
    parameter longint CFG_TMO_CYC = 50 // update timeout cycles
) (
    input wire logic                   hclk,        // clock
    input wire logic                   hresetn,     // reset, low
    input wire logic                   general_output_pin_in,    // wake pin
    input wire logic                   gauging_run, // gauging on
    input wire logic                   cpu_halt,    // cpu halted
    input wire logic                   hf_clk_en,   // fast clock gate
    input wire logic                   ldo_en,      // regulator
    input wire logic                   rom_copy,    // defaults copy
    input wire bgm_pkg::bgm_state_type mode         // mode
);
    longint cnt_q;
    // cycles spent in update mode, zero outside it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_q <= 0;
        else cnt_q <= (mode == BGM_ST_CFGUP) ? cnt_q + 1 : 0;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_POR_INIT: assert property (mode == BGM_ST_POR |=> mode == BGM_ST_INIT)
        else $error("reset not followed by init");
    AST_ROM_COPY: assert property (mode == BGM_ST_POR |=> rom_copy)
        else $error("no defaults copy after reset");
    AST_NORMAL_RUN: assert property ($stable(mode) && mode == BGM_ST_NORMAL
        |-> gauging_run && ldo_en && hf_clk_en && !cpu_halt) else $error("normal not powered");
    AST_SLEEP_CLK: assert property ($stable(mode) && mode == BGM_ST_SLEEP |-> !hf_clk_en)
        else $error("fast clock on in sleep");
    AST_SHUT_LDO: assert property ($stable(mode) && mode == BGM_ST_SHUTDOWN |-> !ldo_en)
        else $error("regulator on in shutdown");
    AST_CFG_HOLD: assert property ($stable(mode) && mode == BGM_ST_CFGUP |-> !gauging_run)
        else $error("gauging in update mode");
    AST_SHUT_LOW: assert property ((!general_output_pin_in)[*3] ##0 mode == BGM_ST_SHUTDOWN
        |=> mode == BGM_ST_SHUTDOWN) else $error("wake with pin low");
    AST_SHUT_HOLD: assert property (mode == BGM_ST_SHUTDOWN && $rose(general_output_pin_in)
        |-> (mode == BGM_ST_SHUTDOWN)[*8]) else $error("wake too early");
    AST_CFG_TMO: assert property (cnt_q <= CFG_TMO_CYC + 2)
        else $error("update mode timeout missed");
    cover property (mode == BGM_ST_CFGUP ##1 mode == BGM_ST_NORMAL);
    cover property (mode == BGM_ST_SHUTDOWN ##1 mode == BGM_ST_POR);
    cover property (mode == BGM_ST_SLEEP);
endmodule
bind bgm_mode_ctrl bgm_mode_ctrl_properties #(.CFG_TMO_CYC(CFG_TMO_CYC)) u_props (
    .hclk(hclk), .hresetn(hresetn), .general_output_pin_in(general_output_pin_in), .gauging_run(gauging_run),
    .cpu_halt(cpu_halt), .hf_clk_en(hf_clk_en), .ldo_en(ldo_en), .rom_copy(rom_copy),
    .mode(mode));
`default_nettype wire

// file: bgm_mode_ctrl_tb.sv
// self-checking bench of the mode controller over AHB-Lite
// assumes zero-wait slave; drives all change just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module bgm_mode_ctrl_tb;
    import bgm_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, general_output_pin_out, general_output_pin_oe, pin_drv;
    logic gauging_run, cpu_halt, hf_clk_en, ldo_en, measure_pulse, rom_copy, ocv_start;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [15:0] internal_temp, gauge_temp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    bgm_state_type mode;
    wire logic general_output_pin_in = general_output_pin_oe ? general_output_pin_out : pin_drv;
    int failures, compares, n;
    logic [9:0] tbl [7] = '{{8'd30, 2'h0}, {8'd19, 2'h2}, {8'd20, 2'h2}, {8'd9, 2'h3},
                            {8'd12, 2'h3}, {8'd16, 2'h2}, {8'd21, 2'h0}};
    logic [7:0] xc [3] = '{8'h42, 8'h43, 8'h44};
    bgm_mode_ctrl #(.CFG_TMO_CYC(50), .WAKE_CYC(10), .SLEEP_TICK(20)) u_bgm_mode_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .internal_temp(internal_temp),
        .general_output_pin_in(general_output_pin_in), .general_output_pin_out(general_output_pin_out), .general_output_pin_oe(general_output_pin_oe),
        .gauge_temp(gauge_temp), .gauging_run(gauging_run), .cpu_halt(cpu_halt),
        .hf_clk_en(hf_clk_en), .ldo_en(ldo_en), .measure_pulse(measure_pulse),
        .rom_copy(rom_copy), .ocv_start(ocv_start), .mode(mode));
    bgm_host_model u_bgm_host_model (.hclk(hclk), .sens_temp(internal_temp), .pin_drv(pin_drv));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic end_of_test;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
            failures++;
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) begin
            @(posedge hclk);
            #1;
        end
    endtask
    // sample before the edge, so hready and hrdata are those the edge sees
    task automatic wt;
        logic r;
        n = 0;
        do begin
            q = hrdata;
            r = hreadyout;
            cyc(1);
            n++;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
    endtask
    task automatic waitm(input bgm_state_type s);
        n = 0;
        while (mode !== s && n < 400) begin
            cyc(1);
            n++;
        end
        chk({25'h0, mode}, {25'h0, s});
    endtask
    task automatic s_reset;
        bus(0, BGM_OFS_CFG, 0); chk(q, BGM_CFG_RESET);
        bus(0, BGM_OFS_THR, 0); chk(q, BGM_THR_RESET);
        bus(0, BGM_OFS_SOC, 0); chk(q, 32'h0000_0064);
        bus(0, BGM_OFS_STATUS, 0); chk(q & 32'h0000_7F20, {17'h0, BGM_ST_INIT, 8'h20});
        bus(1, 8'h1C, 32'hFFFF_FFFF);
        bus(0, 8'h1C, 0); chk(q, 32'h0);
    endtask
    task automatic s_init;
        bus(1, BGM_OFS_EVT, 32'h4);
        cyc(2); chk({31'h0, cpu_halt}, 32'h1);
        waitm(BGM_ST_INIT);
        bus(1, BGM_OFS_EVT, 32'h1);
        bus(1, BGM_OFS_EVT, 32'h5);
        waitm(BGM_ST_NORMAL);
        bus(0, BGM_OFS_STATUS, 0); chk(q & 32'h0000_000E, 32'h0000_0008);
    endtask
    task automatic s_flags;
        bus(1, BGM_OFS_THR, 32'h000F_0A14);
        foreach (tbl[i]) begin
            bus(1, BGM_OFS_SOC, {24'h0, tbl[i][9:2]});
            bus(0, BGM_OFS_STATUS, 0); chk({30'h0, q[7:6]}, {30'h0, tbl[i][1:0]});
        end
        bus(1, BGM_OFS_THR, 32'h000F_FF14);
        bus(1, BGM_OFS_SOC, 32'h5);
        bus(0, BGM_OFS_STATUS, 0); chk({30'h0, q[7:6]}, 32'h2);
        bus(1, BGM_OFS_SOC, 32'h64);
    endtask
    task automatic s_temp;
        bus(1, BGM_OFS_TEMP, 32'h0456);
        bus(0, BGM_OFS_TEMP, 0); chk(q, 32'h0123);
        chk({16'h0, gauge_temp}, 32'h0123);
        bus(1, BGM_OFS_CFG, 32'h3);
        bus(0, BGM_OFS_TEMP, 0); chk(q, 32'h0456);
        chk({16'h0, gauge_temp}, 32'h0456);
        bus(1, BGM_OFS_CFG, 32'h2);
    endtask
    task automatic s_cfg;
        foreach (xc[i]) begin
            bus(1, BGM_OFS_CMD, 32'h13);
            bus(0, BGM_OFS_STATUS, 0); chk({31'h0, q[4]}, 32'h1);
            chk({31'h0, gauging_run}, 32'h0);
            bus(1, BGM_OFS_CMD, {24'h0, xc[i]});
            bus(0, BGM_OFS_STATUS, 0); chk({30'h0, q[5:4]}, 32'h0);
            cyc(2); chk({31'h0, gauging_run}, 32'h1);
        end
        bus(1, BGM_OFS_CMD, 32'h13);
        cyc(30);
        bus(1, BGM_OFS_CMD, 32'h43);
        bus(1, BGM_OFS_CMD, 32'h13);
        waitm(BGM_ST_NORMAL); chk(32'(n >= 45 && n <= 53), 32'h1);
    endtask
    task automatic s_rst_cmd;
        bus(1, BGM_OFS_CMD, 32'h41);
        cyc(2);
        bus(0, BGM_OFS_STATUS, 0); chk(q & 32'h0000_7F20, {17'h0, BGM_ST_INIT, 8'h20});
        bus(1, BGM_OFS_EVT, 32'h1);
        bus(1, BGM_OFS_EVT, 32'h5);
        waitm(BGM_ST_NORMAL);
    endtask
    task automatic s_sleep;
        bus(1, BGM_OFS_EVT, 32'h3);
        waitm(BGM_ST_SLEEP);
        n = 0;
        while (measure_pulse !== 1'b1 && n < 100) begin
            n++;
            cyc(1);
        end
        chk({31'h0, measure_pulse}, 32'h1);
        bus(1, BGM_OFS_EVT, 32'h1);
        waitm(BGM_ST_NORMAL);
    endtask
    task automatic s_hiber;
        bus(1, BGM_OFS_CMD, 32'h11);
        cyc(1); chk({25'h0, mode}, {25'h0, BGM_ST_HIBER});
        chk({31'h0, hf_clk_en}, 32'h0);
        bus(1, BGM_OFS_EVT, 32'h9);
        waitm(BGM_ST_NORMAL);
    endtask
    task automatic s_shut;
        bus(1, BGM_OFS_CMD, 32'h1C);
        bus(1, BGM_OFS_CMD, 32'h1B);
        bus(1, BGM_OFS_CMD, 32'h43);
        bus(1, BGM_OFS_CMD, 32'h1C);
        cyc(2); chk({25'h0, mode}, {25'h0, BGM_ST_NORMAL});
        bus(1, BGM_OFS_CMD, 32'h1B);
        bus(1, BGM_OFS_CMD, 32'h1C);
        waitm(BGM_ST_SHUTDOWN); chk({31'h0, ldo_en}, 32'h0);
        u_bgm_host_model.wake(5);
        cyc(5); chk({25'h0, mode}, {25'h0, BGM_ST_SHUTDOWN});
        u_bgm_host_model.wake(20);
        waitm(BGM_ST_INIT);
        bus(0, BGM_OFS_STATUS, 0); chk({31'h0, q[5]}, 32'h1);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        failures = 0;
        compares = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        cyc(1);
        s_reset();
        s_init();
        s_flags();
        s_temp();
        s_cfg();
        s_rst_cmd();
        s_sleep();
        s_hiber();
        s_shut();
        end_of_test();
    end
endmodule
`default_nettype wire
